// file: logic/hipc_power_ctrl.sv
// halt and idle power controller with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
// How it works
// - halt flag write stops core clock, timers
// - halt inhibits watchdog; monitor drives fault low
// - halt exits on wake edge, osc pin in RC mode, reset
// - wake loads idle timer 256, then clocks
// - instruction clock is oscillator divided ten
// - RC startup delay only if select set
// - halt-disable option ignores halt flag write
// - idle flag enters idle; timer keeps running
// - state and other timers hold in low power
// - idle exits on reset, wake, timer toggle
// - timer bit twelve toggle sets pending flag
// - timer interrupt only when enable bit set
// - enabled idle exit runs timer service first
// - disabled idle exit resumes next instruction
// - idle timer sixteen-bit free down-counter
// - halt refused while wake enabled and pending
module hipc_power_ctrl
    import hipc_pkg::*;
#(
    parameter bit HALT_DISABLE = 1'b0,
    parameter bit RC_CLOCK     = 1'b0,
    parameter int WAKE_W       = 8
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address, data and response
    input  wire logic [hipc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [hipc_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read
    input  wire logic [hipc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [hipc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // pins
    input  wire logic [WAKE_W-1:0]      wake_pins,
    input  wire logic                   osc_output_pin,
    input  wire logic                   reset_pin_n,
    // power outputs
    output logic                        core_clk_en,
    output logic                        osc_enable,
    output logic                        watchdog_fault_output_n,
    output logic                        watchdog_enable,
    output logic                        resume_service,
    output logic                        irq
);
    import hipc_pkg::*;

    hipc_state_t            state;
    hipc_state_t            next_state;
    logic [3:0]             div_cnt;
    logic [TMR_W-1:0]       idle_timer;
    logic                   idle_timer_pending;
    logic                   idle_timer_int_enable;
    logic                   startup_delay_select;
    logic                   clk_mon_en;
    logic                   wd_first_done;
    logic                   tmr_from_idle;
    logic [WAKE_W-1:0]      wake_enable_bits;
    logic [WAKE_W-1:0]      wake_edge_neg;
    logic [WAKE_W-1:0]      wake_pending_bits;
    logic [IRQ_N-1:0]       irq_stat;
    logic [IRQ_N-1:0]       irq_en;
    logic [2:0]             osc_s;
    logic [1:0]             rst_s;
    logic                   aw_held;
    logic                   w_held;
    logic [ADDR_W-1:0]      aw_addr;
    logic [DATA_W-1:0]      w_data;
    logic [3:0]             w_strb;

    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : is_reg

    // instruction clock enable, oscillator divided by ten
    wire tick = (div_cnt == 4'(OSC_DIV - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // write channel capture
    wire wr_go   = aw_held && w_held && !s_axi_bvalid;
    wire wr_lane = w_strb[0];
    wire wr_ctrl = wr_go && wr_lane && is_reg(aw_addr, OFS_CTRL);
    wire wr_cfg  = wr_go && wr_lane && is_reg(aw_addr, OFS_CONFIG);
    wire wr_wen  = wr_go && wr_lane && is_reg(aw_addr, OFS_WAKE_EN);
    wire wr_wedg = wr_go && wr_lane && is_reg(aw_addr, OFS_WAKE_EDGE);
    wire wr_wpnd = wr_go && wr_lane && is_reg(aw_addr, OFS_WAKE_PEND);
    wire wr_ien  = wr_go && wr_lane && is_reg(aw_addr, OFS_IRQ_EN);
    wire wr_iclr = wr_go && wr_lane && is_reg(aw_addr, OFS_IRQ_CLR);
    wire wr_wds  = wr_go && wr_lane && is_reg(aw_addr, OFS_WD_SVC);
    wire wr_hit  = is_reg(aw_addr, OFS_CTRL) || is_reg(aw_addr, OFS_CONFIG)
                || is_reg(aw_addr, OFS_WAKE_EN) || is_reg(aw_addr, OFS_WAKE_EDGE)
                || is_reg(aw_addr, OFS_WAKE_PEND) || is_reg(aw_addr, OFS_IRQ_EN)
                || is_reg(aw_addr, OFS_IRQ_CLR) || is_reg(aw_addr, OFS_WD_SVC);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    // synchronised pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_s <= '0;
            rst_s <= 2'b11;
        end else begin
            osc_s <= {osc_s[1:0], osc_output_pin};
            rst_s <= {rst_s[0], reset_pin_n};
        end
    end
    wire osc_rise = osc_s[1] && !osc_s[2] && RC_CLOCK;
    wire pin_rst  = !rst_s[1];

    // wakeup port
    wire [WAKE_W-1:0] wk_clr = wr_wpnd ? ~w_data[WAKE_W-1:0] : '0;
    hipc_wake_detect #(.WIDTH(WAKE_W)) u_wake (
        .aclk      (aclk),
        .aresetn   (aresetn && !pin_rst),
        .wake_pins (wake_pins),
        .edge_neg  (wake_edge_neg),
        .clr_mask  (wk_clr),
        .set_mask  ('0),
        .pend      (wake_pending_bits)
    );
    wire wake_hit    = |(wake_enable_bits & wake_pending_bits);
    wire halt_req    = wr_ctrl && w_data[CTRL_HALT] && (state == HIPC_RUN);
    wire halt_refuse = halt_req && (HALT_DISABLE || wake_hit);
    wire halt_go     = halt_req && !halt_refuse;
    wire idle_go     = wr_ctrl && w_data[CTRL_IDLE] && (state == HIPC_RUN)
                       && !halt_go && !halt_refuse;

    // idle timer, free running except in halt
    wire tmr_run    = tick && (state != HIPC_HALT);
    wire [TMR_W-1:0] tmr_dec = idle_timer - 16'h0001;
    wire tmr_toggle = tmr_run && (tmr_dec[TOGGLE_BIT] != idle_timer[TOGGLE_BIT]);
    wire start_done = (state == HIPC_START) && tmr_run && (idle_timer == '0);
    wire use_delay  = !RC_CLOCK || startup_delay_select;
    wire halt_wake  = (state == HIPC_HALT) && (wake_hit || osc_rise);
    wire idle_wake  = (state == HIPC_IDLE) && (wake_hit || tmr_toggle);

    always_comb begin
        next_state = state;
        case (state)
            HIPC_RUN: begin
                if (halt_go) begin
                    next_state = HIPC_HALT;
                end else if (idle_go) begin
                    next_state = HIPC_IDLE;
                end
            end
            HIPC_HALT: begin
                if (halt_wake) begin
                    next_state = use_delay ? HIPC_START : HIPC_RUN;
                end
            end
            HIPC_IDLE: begin
                if (idle_wake) begin
                    next_state = HIPC_RUN;
                end
            end
            HIPC_START: begin
                if (start_done) begin
                    next_state = HIPC_RUN;
                end
            end
            default: next_state = HIPC_RUN;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || pin_rst) begin
            state      <= HIPC_RUN;
            idle_timer <= '0;
        end else begin
            state <= next_state;
            if (halt_wake && use_delay) begin
                idle_timer <= STARTUP_LOAD;
            end else if (tmr_run) begin
                idle_timer <= tmr_dec;
            end
        end
    end

    // configuration, flags and watchdog service
    always_ff @(posedge aclk) begin
        if (!aresetn || pin_rst) begin
            idle_timer_pending    <= 1'b0;
            idle_timer_int_enable <= 1'b0;
            startup_delay_select  <= 1'b0;
            clk_mon_en            <= 1'b1;
            wd_first_done         <= 1'b0;
            wake_enable_bits      <= '0;
            wake_edge_neg         <= '0;
            irq_en                <= '0;
            tmr_from_idle         <= 1'b0;
        end else begin
            if (wr_cfg) begin
                idle_timer_int_enable <= w_data[CFG_TMR_IE];
                startup_delay_select  <= w_data[CFG_DLY_SEL];
                idle_timer_pending    <= w_data[CFG_TMR_IE + 3];
            end
            if (tmr_toggle) begin
                idle_timer_pending <= 1'b1;
            end
            // first service write may turn the clock monitor off
            if (wr_wds) begin
                wd_first_done <= 1'b1;
                if (!wd_first_done) begin
                    clk_mon_en <= w_data[WDS_CLK_MON];
                end
            end
            if (wr_wen) begin
                wake_enable_bits <= w_data[WAKE_W-1:0];
            end
            if (wr_wedg) begin
                wake_edge_neg <= w_data[WAKE_W-1:0];
            end
            if (wr_ien) begin
                irq_en <= w_data[IRQ_N-1:0];
            end
            if (idle_wake) begin
                tmr_from_idle <= tmr_toggle && idle_timer_int_enable;
            end else if (state == HIPC_RUN && wr_cfg) begin
                tmr_from_idle <= 1'b0;
            end
        end
    end

    // sticky event status, set wins over clear
    wire [IRQ_N-1:0] ev;
    assign ev[IRQ_TMR]    = tmr_toggle && idle_timer_int_enable;
    assign ev[IRQ_WAKE]   = halt_wake || (idle_wake && wake_hit);
    assign ev[IRQ_EXIT]   = (next_state == HIPC_RUN) && (state != HIPC_RUN);
    assign ev[IRQ_REFUSE] = halt_refuse;
    wire [IRQ_N-1:0] iclr = wr_iclr ? w_data[IRQ_N-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~iclr) | ev;
            irq      <= |(((irq_stat & ~iclr) | ev) & irq_en);
        end
    end

    // power outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_clk_en             <= 1'b1;
            osc_enable              <= 1'b1;
            watchdog_fault_output_n <= 1'b1;
            watchdog_enable         <= 1'b1;
            resume_service          <= 1'b0;
        end else begin
            core_clk_en    <= (next_state == HIPC_RUN);
            osc_enable     <= (next_state != HIPC_HALT);
            watchdog_enable <= (next_state != HIPC_HALT);
            watchdog_fault_output_n <= !((next_state == HIPC_HALT) && clk_mon_en);
            resume_service <= idle_wake && tmr_toggle && idle_timer_int_enable;
        end
    end

    // read channel
    wire [ADDR_W-1:0] ra = s_axi_araddr;
    wire rd_ok = is_reg(ra, OFS_CTRL) || is_reg(ra, OFS_CONFIG) || is_reg(ra, OFS_STATUS)
              || is_reg(ra, OFS_WAKE_EN) || is_reg(ra, OFS_WAKE_EDGE)
              || is_reg(ra, OFS_WAKE_PEND) || is_reg(ra, OFS_IRQ_STAT)
              || is_reg(ra, OFS_IRQ_EN) || is_reg(ra, OFS_IRQ_CLR) || is_reg(ra, OFS_WD_SVC);
    wire [DATA_W-1:0] rd_val =
        is_reg(ra, OFS_CONFIG)    ? DATA_W'({clk_mon_en, startup_delay_select,
                                             idle_timer_int_enable}) :
        is_reg(ra, OFS_STATUS)    ? DATA_W'({tmr_from_idle, idle_timer_pending, state}) :
        is_reg(ra, OFS_WAKE_EN)   ? DATA_W'(wake_enable_bits) :
        is_reg(ra, OFS_WAKE_EDGE) ? DATA_W'(wake_edge_neg) :
        is_reg(ra, OFS_WAKE_PEND) ? DATA_W'(wake_pending_bits) :
        is_reg(ra, OFS_IRQ_STAT)  ? DATA_W'(irq_stat) :
        is_reg(ra, OFS_IRQ_EN)    ? DATA_W'(irq_en) : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    // checks
    halt_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
        halt_go |=> (state == HIPC_HALT) ##1 !core_clk_en) else $error("halt not entered");
    halt_wd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == HIPC_HALT) && clk_mon_en && $past(state == HIPC_HALT)
        |-> !watchdog_fault_output_n) else $error("fault not low in halt");
    sequence wake_seq;
        halt_wake && use_delay && !pin_rst;
    endsequence
    startup_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_seq |=> (idle_timer == STARTUP_LOAD) && (state == HIPC_START))
        else $error("startup load wrong");
    div_ten_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick |=> !tick [*8] ##1 !tick ##1 tick) else $error("divider not ten");
    halt_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        halt_refuse |=> state == HIPC_RUN) else $error("refused halt entered");
    idle_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
        idle_go && !pin_rst |=> state == HIPC_IDLE) else $error("idle not entered");
    tmr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == HIPC_HALT) && $past(state == HIPC_HALT) && !pin_rst && !halt_wake
        |=> $stable(idle_timer)) else $error("timer ran in halt");
    pend_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tmr_toggle && !pin_rst |=> idle_timer_pending) else $error("pending not set");
    idle_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        idle_wake && !pin_rst |=> state == HIPC_RUN ##1 core_clk_en)
        else $error("idle exit missed");
endmodule : hipc_power_ctrl
`default_nettype wire

// file: logic/hipc_pkg.sv
// constants, register map and types for the halt and idle power controller
package hipc_pkg;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_CONFIG    = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;
    localparam logic [7:0]  OFS_WAKE_EN   = 8'h0C;
    localparam logic [7:0]  OFS_WAKE_EDGE = 8'h10;
    localparam logic [7:0]  OFS_WAKE_PEND = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h18;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h1C;
    localparam logic [7:0]  OFS_IRQ_CLR   = 8'h20;
    localparam logic [7:0]  OFS_WD_SVC    = 8'h24;
    // control register fields
    localparam int          CTRL_IDLE     = 6;
    localparam int          CTRL_HALT     = 7;
    // config register fields
    localparam int          CFG_TMR_IE    = 0;
    localparam int          CFG_DLY_SEL   = 1;
    localparam int          CFG_CLK_MON   = 2;
    // watchdog service register field for clock monitor enable
    localparam int          WDS_CLK_MON   = 0;
    // interrupt status bits
    localparam int          IRQ_N         = 4;
    localparam int          IRQ_TMR       = 0;
    localparam int          IRQ_WAKE      = 1;
    localparam int          IRQ_EXIT      = 2;
    localparam int          IRQ_REFUSE    = 3;
    // timing
    localparam int          OSC_DIV       = 10;
    localparam int          TMR_W         = 16;
    localparam logic [15:0] STARTUP_LOAD  = 16'h0100;
    localparam int          TOGGLE_BIT    = 12;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef enum logic [3:0] {
        HIPC_RUN   = 4'b0001,
        HIPC_HALT  = 4'b0010,
        HIPC_IDLE  = 4'b0100,
        HIPC_START = 4'b1000
    } hipc_state_t;
endpackage : hipc_pkg

// file: logic/hipc_wake_detect.sv
// edge detector for the wakeup port with pending latch
`timescale 1ns/100ps
`default_nettype none
module hipc_wake_detect #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // pins and control
    input  wire logic [WIDTH-1:0] wake_pins,
    input  wire logic [WIDTH-1:0] edge_neg,
    input  wire logic [WIDTH-1:0] clr_mask,
    input  wire logic [WIDTH-1:0] set_mask,
    // pending flags
    output logic      [WIDTH-1:0] pend
);
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] prev;
    wire  [WIDTH-1:0] rise = sync2 & ~prev;
    wire  [WIDTH-1:0] fall = ~sync2 & prev;
    wire  [WIDTH-1:0] hit  = (edge_neg & fall) | (~edge_neg & rise);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            prev  <= '0;
            pend  <= '0;
        end else begin
            sync1 <= wake_pins;
            sync2 <= sync1;
            prev  <= sync2;
            // a new edge wins over a clear
            pend  <= ((pend & ~clr_mask) | set_mask) | hit;
        end
    end
endmodule : hipc_wake_detect
`default_nettype wire

// file: verification/hipc_far_model.sv
// model of the wakeup, oscillator and reset pins driven from outside the controller
`timescale 1ns/100ps
`default_nettype none
module hipc_far_model (
    // clock
    input  wire logic       aclk,
    // commands from the bench
    input  wire logic [7:0] wake_cmd,
    input  wire logic       rst_cmd_n,
    // pins
    output logic      [7:0] wake_pins,
    output logic            osc_output_pin,
    output logic            reset_pin_n
);
    logic [7:0] pins_q = 8'h00;
    logic       rst_q  = 1'b1;

    // pin levels move just after an edge, like any external source
    always @(posedge aclk) begin
        pins_q <= wake_cmd;
        rst_q  <= rst_cmd_n;
    end
    assign wake_pins      = pins_q;
    // crystal clocking: the oscillator pin carries no wake edge
    assign osc_output_pin = 1'b0;
    assign reset_pin_n    = rst_q;
endmodule : hipc_far_model
`default_nettype wire

// file: verification/hipc_power_ctrl_tb.sv
// self-checking bench for the halt and idle power controller
`timescale 1ns/100ps
`default_nettype none
module hipc_power_ctrl_tb;
    import hipc_pkg::*;
    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic [7:0]  wake_cmd      = 8'h00;
    logic        rst_cmd_n     = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd;
    logic [1:0]  rs;
    logic        core_clk_en, osc_enable, watchdog_fault_output_n;
    logic        watchdog_enable, resume_service, irq;
    wire  [7:0]  wake_pins;
    wire         osc_output_pin, reset_pin_n;
    int          n_mismatch = 0, n_compared = 0, n_resume = 0, cnt, b;

    hipc_power_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_pins, .osc_output_pin, .reset_pin_n,
        .core_clk_en, .osc_enable, .watchdog_fault_output_n, .watchdog_enable,
        .resume_service, .irq);
    hipc_far_model u_far (.aclk, .wake_cmd, .rst_cmd_n, .wake_pins, .osc_output_pin,
        .reset_pin_n);

    initial begin
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (resume_service === 1'b1) n_resume++;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit aw_done = 1'b0;
        bit w_done  = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic wait_run(input int limit);
        cnt = 0;
        while (core_clk_en !== 1'b1 && cnt < limit) begin
            @(posedge aclk);
            cnt++;
        end
    endtask : wait_run

    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (100000) @(posedge aclk);
        n_mismatch++;
        close_out;
    end

    initial begin
        void'($urandom(32'hBA257529));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("core_clk_en", 32'h1, core_clk_en);
        chk("irq", 32'h0, irq);
        axi_rd(OFS_STATUS);
        chk("state", 32'h1, rd & 32'hF);
        axi_rd(8'hFC);
        chk("unmapped resp", RESP_SLVERR, rs);
        $display("test reset done");
        b = $urandom % 8;
        axi_wr(OFS_WAKE_EN, 32'h1 << b);
        axi_rd(OFS_WAKE_EN);
        chk("wake_en", 32'h1 << b, rd);
        axi_wr(OFS_CTRL, 32'h80);
        axi_rd(OFS_STATUS);
        chk("halt state", 32'h2, rd & 32'hF);
        chk("core_clk_en halt", 32'h0, core_clk_en);
        chk("osc_enable halt", 32'h0, osc_enable);
        chk("watchdog_enable", 32'h0, watchdog_enable);
        chk("fault_n", 32'h0, watchdog_fault_output_n);
        wake_cmd <= 8'h01 << b;
        wait_run(4000);
        chk("startup span", 32'h1, cnt >= 2550 && cnt <= 2590);
        chk("fault_n run", 32'h1, watchdog_fault_output_n);
        $display("test halt wake done");
        axi_wr(OFS_IRQ_EN, 32'h8);
        axi_wr(OFS_CTRL, 32'h80);
        axi_rd(OFS_STATUS);
        chk("refused state", 32'h1, rd & 32'hF);
        chk("irq refused", 32'h1, irq);
        axi_rd(OFS_IRQ_STAT);
        chk("irq stat", 32'hE, rd);
        axi_wr(OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq masked", 32'h0, irq);
        axi_wr(OFS_IRQ_CLR, 32'hF);
        axi_rd(OFS_IRQ_STAT);
        chk("irq stat clr", 32'h0, rd);
        $display("test refuse done");
        axi_wr(OFS_WAKE_PEND, 32'h0);
        axi_wr(OFS_CONFIG, 32'h1);
        axi_wr(OFS_CTRL, 32'h40);
        axi_rd(OFS_STATUS);
        chk("idle state", 32'h4, rd & 32'hF);
        chk("osc idle", 32'h1, osc_enable);
        wait_run(45000);
        chk("idle exit", 32'h1, cnt < 45000);
        repeat (2) @(posedge aclk);
        chk("resume pulses", 32'h1, n_resume);
        axi_rd(OFS_STATUS);
        chk("timer pending", 32'h31, rd & 32'h3F);
        axi_rd(OFS_IRQ_STAT);
        chk("timer event", 32'h1, rd & 32'h1);
        $display("test idle done");
        axi_wr(OFS_WD_SVC, 32'h0);
        axi_wr(OFS_CTRL, 32'h80);
        repeat (2) @(posedge aclk);
        axi_rd(OFS_STATUS);
        chk("quiet halt state", 32'h2, rd & 32'hF);
        chk("fault_n monitor off", 32'h1, watchdog_fault_output_n);
        chk("watchdog_enable off", 32'h0, watchdog_enable);
        rst_cmd_n <= 1'b0;
        repeat (6) @(posedge aclk);
        rst_cmd_n <= 1'b1;
        wait_run(20);
        chk("reset pin exit", 32'h1, cnt < 20);
        axi_rd(OFS_STATUS);
        chk("reset pin state", 32'h1, rd & 32'hF);
        axi_wr(OFS_WAKE_EDGE, 32'h1 << b);
        axi_wr(OFS_WAKE_PEND, 32'h0);
        axi_wr(OFS_WAKE_EN, 32'h1 << b);
        axi_wr(OFS_CTRL, 32'h40);
        repeat (2) @(posedge aclk);
        wake_cmd <= 8'h00;
        wait_run(100);
        chk("idle wake exit", 32'h1, cnt < 100);
        repeat (2) @(posedge aclk);
        chk("no resume pulse", 32'h1, n_resume);
        axi_rd(OFS_STATUS);
        chk("plain resume", 32'h1, rd & 32'h2F);
        $display("test reset pin and wake done");
        close_out;
    end
endmodule : hipc_power_ctrl_tb
`default_nettype wire
